// ### adcst_timer.sv
// sample and conversion phase timer of the on-chip converter
// assumes start and write strobes from logic on clk_i
//
// Contract
// - sample lasts 8 per count plus 2
// - conversion lasts 2*bits*(count+1)+3 cycles
// - sample count 1 to 7 accepted
// - conversion count 2 to 31 accepted
// - sample connects input, then conversion resolves
// - one timing register governs later conversions
`timescale 1ns/1ps
`include "adcst_consts.svh"

module adcst_timer
  import adcst_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic timing_wr_i,
  input wire adcst_timing_t timing_wdata_i,
  input wire logic ten_bit_i,
  input wire logic start_i,
  input wire logic comparator_i,
  output adcst_timing_t timing_o,
  output logic sample_connect_o,
  output logic converting_o,
  output logic busy_o,
  output logic done_o,
  output logic [`ADCST_RES_W-1:0] result_o
);

  adcst_timing_t timing_q;
  adcst_state_t state_q;
  logic [`ADCST_CNT_W-1:0] cnt_q;
  logic [`ADCST_CNT_W-1:0] step_cnt_q;
  logic [`ADCST_CNT_W-1:0] sample_dur;
  logic [`ADCST_CNT_W-1:0] conversion_time_count_dur;
  logic [`ADCST_CNT_W-1:0] step_len;
  logic ten_bit_q;
  logic done_q;
  logic [`ADCST_RES_W-1:0] result_q;
  logic [3:0] bit_idx_q;
  logic [3:0] bits_left;
  logic start_take;
  logic sample_end;
  logic conversion_time_count_end;
  logic step_end;
  wire [`ADCST_RES_W-1:0] sar_bits;

  // ----------------------------------------
  // timing register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timing_q <= '{sample_time_count: `ADCST_SAM_RESET, conversion_time_count: `ADCST_CONVERSION_TIME_COUNT_RESET};
    end else if (timing_wr_i) begin
      timing_q <= timing_wdata_i;
    end
  end

  adcst_duration adcst_duration_i (
    .timing_i(timing_q),
    .ten_bit_i(ten_bit_q),
    .sample_duration_o(sample_dur),
    .conversion_duration_o(conversion_time_count_dur)
  );

  // ----------------------------------------
  // phase boundaries
  // ----------------------------------------
  assign start_take = start_i && (state_q == ADCST_IDLE);
  assign sample_end = (state_q == ADCST_SAMPLE) && (cnt_q >= sample_dur);
  assign conversion_time_count_end = (state_q == ADCST_CONVERT) && (cnt_q >= conversion_time_count_dur);

  // ----------------------------------------
  // phase state
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ADCST_IDLE;
    end else begin
      case (state_q)
        ADCST_IDLE: begin
          if (start_take) begin
            state_q <= ADCST_SAMPLE;
          end
        end
        ADCST_SAMPLE: begin
          if (sample_end) begin
            state_q <= ADCST_CONVERT;
          end
        end
        ADCST_CONVERT: begin
          if (conversion_time_count_end) begin
            state_q <= ADCST_IDLE;
          end
        end
        default: begin
          state_q <= ADCST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // phase counter
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (start_take || sample_end) begin
      cnt_q <= `ADCST_CNT_W'(1);
    end else if (conversion_time_count_end || (state_q == ADCST_IDLE)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + `ADCST_CNT_W'(1);
    end
  end

  // ----------------------------------------
  // width capture
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ten_bit_q <= 1'b1;
    end else if (start_take) begin
      ten_bit_q <= ten_bit_i;
    end
  end

  // ----------------------------------------
  // step timing
  // ----------------------------------------
  assign step_len = `ADCST_CNT_W'(`ADCST_CONVERSION_TIME_COUNT_MULT * (timing_q.conversion_time_count + 1));
  assign bits_left = ten_bit_q ? `ADCST_BITS_10 : `ADCST_BITS_8;
  assign step_end = (state_q == ADCST_CONVERT) && (bit_idx_q < bits_left) && (step_cnt_q == step_len);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_cnt_q <= '0;
    end else if (sample_end) begin
      step_cnt_q <= `ADCST_CNT_W'(1);
    end else if (state_q != ADCST_CONVERT) begin
      step_cnt_q <= '0;
    end else if (step_cnt_q >= step_len) begin
      step_cnt_q <= `ADCST_CNT_W'(1);
    end else begin
      step_cnt_q <= step_cnt_q + `ADCST_CNT_W'(1);
    end
  end

  // ----------------------------------------
  // bit position
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_idx_q <= 4'h0;
    end else if (state_q == ADCST_SAMPLE) begin
      bit_idx_q <= 4'h0;
    end else if (step_end) begin
      bit_idx_q <= bit_idx_q + 4'h1;
    end
  end

  // ----------------------------------------
  // approximation bits, msb first
  // ----------------------------------------
  for (genvar j = 0; j < `ADCST_RES_W; j++) begin : g_sar
    logic bit_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        bit_q <= 1'b0;
      end else if (state_q == ADCST_SAMPLE) begin
        bit_q <= 1'b0;
      end else if (step_end && (bit_idx_q == 4'(`ADCST_RES_W - 1 - j))) begin
        bit_q <= comparator_i;
      end
    end
    assign sar_bits[j] = bit_q;
  end

  // ----------------------------------------
  // result register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_q <= '0;
    end else if (conversion_time_count_end) begin
      if (ten_bit_q) begin
        result_q <= sar_bits;
      end else begin
        result_q <= {2'h0, sar_bits[`ADCST_RES_W-1 -: 8]};
      end
    end
  end

  // ----------------------------------------
  // completion pulse
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= conversion_time_count_end;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign timing_o = timing_q;
  assign sample_connect_o = (state_q == ADCST_SAMPLE);
  assign converting_o = (state_q == ADCST_CONVERT);
  assign busy_o = (state_q != ADCST_IDLE);
  assign done_o = done_q;
  assign result_o = result_q;

endmodule : adcst_timer

// ### adcst_consts.svh
// constants for the converter sample/convert timing block
// assumes inclusion by the package and the modules of this block
`ifndef ADCST_CONSTS_SVH
`define ADCST_CONSTS_SVH

// ----------------------------------------
// clock and timing formula
// ----------------------------------------
`define ADCST_CLK_MHZ 10
`define ADCST_SAM_MULT 8
`define ADCST_SAM_EXTRA 2
`define ADCST_CONVERSION_TIME_COUNT_MULT 2
`define ADCST_CONVERSION_TIME_COUNT_EXTRA 3

// ----------------------------------------
// legal ranges of the counts
// ----------------------------------------
`define ADCST_SAM_MIN 3'h1
`define ADCST_SAM_MAX 3'h7
`define ADCST_CONVERSION_TIME_COUNT_MIN 5'h02
`define ADCST_CONVERSION_TIME_COUNT_MAX 5'h1f

// ----------------------------------------
// result and counter widths and reset values
// ----------------------------------------
`define ADCST_BITS_8 4'h8
`define ADCST_BITS_10 4'ha
`define ADCST_SAM_RESET 3'h1
`define ADCST_CONVERSION_TIME_COUNT_RESET 5'h02
`define ADCST_RES_W 10
`define ADCST_CNT_W 11

`endif

// ### adcst_pkg.sv
// types of the converter sample/convert timing block
// assumes adcst_consts.svh is on the include path
`include "adcst_consts.svh"

package adcst_pkg;

  // ----------------------------------------
  // timing register contents
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] sample_time_count;
    logic [4:0] conversion_time_count;
  } adcst_timing_t;

  // ----------------------------------------
  // phase state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ADCST_IDLE,
    ADCST_SAMPLE,
    ADCST_CONVERT
  } adcst_state_t;

endpackage : adcst_pkg

// ### adcst_duration.sv
// phase duration calculator of the sample/convert timer
// assumes stable timing counts while a conversion runs
`timescale 1ns/1ps
`include "adcst_consts.svh"

module adcst_duration
  import adcst_pkg::*;
(
  input wire adcst_timing_t timing_i,
  input wire logic ten_bit_i,
  output logic [`ADCST_CNT_W-1:0] sample_duration_o,
  output logic [`ADCST_CNT_W-1:0] conversion_duration_o
);

  logic [3:0] bits;

  // ----------------------------------------
  // cycle counts of both phases
  // ----------------------------------------
  assign bits = ten_bit_i ? `ADCST_BITS_10 : `ADCST_BITS_8;
  assign sample_duration_o = `ADCST_CNT_W'(`ADCST_SAM_MULT * timing_i.sample_time_count
                             + `ADCST_SAM_EXTRA);
  assign conversion_duration_o = `ADCST_CNT_W'(`ADCST_CONVERSION_TIME_COUNT_MULT * bits
                                 * (timing_i.conversion_time_count + 1) + `ADCST_CONVERSION_TIME_COUNT_EXTRA);

endmodule : adcst_duration

// ### adcst_asserts.sv
// port checker of the sample/convert timer
// assumes it is bound onto adcst_timer
`timescale 1ns/1ps
module adcst_asserts
  import adcst_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic timing_wr_i,
  input wire adcst_timing_t timing_wdata_i,
  input wire logic ten_bit_i,
  input wire logic start_i,
  input wire adcst_timing_t timing_o,
  input wire logic sample_connect_o,
  input wire logic converting_o,
  input wire logic busy_o,
  input wire logic done_o
);
  // --
  // phase length counters
  // --
  logic [10:0] s_q;
  logic [10:0] c_q;
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) s_q <= '0;
    else s_q <= sample_connect_o ? s_q + 11'h1 : 11'h0;
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) c_q <= '0;
    else c_q <= converting_o ? c_q + 11'h1 : 11'h0;
  // width taken with an accepted start
  logic ten_q;
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) ten_q <= 1'b1;
    else if (start_i && !busy_o) ten_q <= ten_bit_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_start; start_i && !busy_o |=> sample_connect_o && busy_o; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_busy; busy_o == (sample_connect_o || converting_o); endproperty
  a_busy: assert property (p_busy) else $error("busy wrong");
  property p_order; $fell(sample_connect_o) |-> converting_o; endproperty
  a_order: assert property (p_order) else $error("no conversion after sample");
  property p_samlen; $fell(sample_connect_o) |-> s_q == 11'(timing_o.sample_time_count) * 11'h8 + 11'h2; endproperty
  a_samlen: assert property (p_samlen) else $error("sample length");
  property p_convlen; $fell(converting_o) |->
    c_q == (ten_q ? 11'h14 : 11'h10) * (11'(timing_o.conversion_time_count) + 11'h1) + 11'h3; endproperty
  a_convlen: assert property (p_convlen) else $error("conversion length");
  property p_done; $fell(converting_o) |-> done_o && !busy_o; endproperty
  a_done: assert property (p_done) else $error("done missing");
  property p_wr; timing_wr_i |=> timing_o == $past(timing_wdata_i); endproperty
  a_wr: assert property (p_wr) else $error("timing write lost");
  property p_pulse; done_o |=> !done_o; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
endmodule : adcst_asserts

bind adcst_timer adcst_asserts adcst_asserts_i(.clk_i, .reset_n_i, .timing_wr_i, .timing_wdata_i, .ten_bit_i,
  .start_i, .timing_o, .sample_connect_o, .converting_o, .busy_o, .done_o);

// ### adcst_timer_tb.sv
// self-checking bench of the sample/convert timer
// assumes the package and checker are compiled first
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin failures++; $display("Error %s exp %h got %h", n, e, s); end end
module adcst_timer_tb import adcst_pkg::*;;
  logic clk_i = 0, reset_n_i = 0, timing_wr_i = 0, ten_bit_i = 0, start_i = 0, comparator_i = 0;
  adcst_timing_t timing_wdata_i = '0, timing_o;
  logic sample_connect_o, converting_o, busy_o, done_o;
  logic [9:0] result_o;
  logic [41:0] exp_q[$];
  logic [41:0] exp_v;
  logic [31:0] seed = 32'h9391543c, cyc = 0, t0 = 0;
  int failures = 0, n_checks = 0;
  adcst_timer adcst_timer_i(.clk_i, .reset_n_i, .timing_wr_i, .timing_wdata_i, .ten_bit_i, .start_i,
    .comparator_i, .timing_o, .sample_connect_o, .converting_o, .busy_o, .done_o, .result_o);
  // --
  // helpers
  // --
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic run(input logic [2:0] s, input logic [4:0] c, input logic t, input logic [9:0] p);
    int nb;
    int sl;
    int d;
    nb = t ? 10 : 8;
    sl = 2 * (c + 1);
    d = 8 * s + 2 + 2 * nb * (c + 1) + 3 + 1;
    timing_wr_i <= 1'b1;
    timing_wdata_i <= {s, c};
    @(posedge clk_i);
    timing_wr_i <= 1'b0;
    start_i <= 1'b1;
    ten_bit_i <= t;
    comparator_i <= ~p[nb - 1];
    exp_q.push_back({32'(d), t ? p : {2'h0, p[7:0]}});
    @(posedge clk_i);
    start_i <= 1'b0;
    `CHK("timing", {s, c}, timing_o)
    repeat (4) @(posedge clk_i);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (8 * s + 2 - 5) @(posedge clk_i);
    for (int k = 0; k < nb; k++) begin
      comparator_i <= p[nb - 1 - k];
      repeat (sl) @(posedge clk_i);
    end
    while (done_o !== 1'b1) @(posedge clk_i);
    $display("test sam %0d conversion_time_count %0d ten %0d done", s, c, t);
  endtask : run
  initial forever #50 clk_i = ~clk_i;
  // --
  // result watcher
  // --
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      failures++;
      wrap_up();
    end
    if (start_i && !busy_o) t0 <= cyc;
    if (done_o === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : {42{1'bx}};
      `CHK("dur_res", exp_v, {cyc - t0, result_o})
    end
  end
  initial begin
    logic [2:0] s_v;
    logic [4:0] c_v;
    logic t_v;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    `CHK("timing_rst", 8'h22, timing_o)
    `CHK("status_rst", 14'h0000, {busy_o, done_o, sample_connect_o, converting_o, result_o})
    for (int i = 0; i < 10; i++) begin
      t_v = i[0];
      s_v = (i == 0) ? 3'h1 : (i == 1) ? 3'h7 : 3'(rnd() % 7 + 1);
      c_v = (i == 0) ? 5'h02 : (i == 2) ? 5'h1f : 5'(rnd() % 30 + 2);
      if (t_v) c_v = 5'(rnd() % 3 + 4);
      run(s_v, c_v, t_v, 10'(rnd()));
    end
    @(posedge clk_i);
    wrap_up();
  end
endmodule : adcst_timer_tb
